// >>> hdl/lpf_freeze_ctrl.sv
`timescale 1ns/10ps
`include "lpf_map.svh"
// Functional notes
// [RULE1] Without the pin input buffer (HAS_PIN_BUF=0) the freeze mode is never configured.
// [RULE2] One pin input buffer exists, fed only by the dedicated freeze request pin.
// [RULE3] Pin pulses shorter than the glitch filter width are rejected.
// [RULE4] Freeze is entered only with the static current enable high and the pin low.
// [RULE5] With the static current enable low, freeze is refused or left.
// [RULE6] Without the access block (HAS_ACCESS=0) the enable reads as high; the pin alone rules.
// [RULE7] Pin-plus-logic control needs both the pin buffer and the access block.
// [RULE8] The static current enable is driven only by the state machine.
// [RULE9] With housekeeping off, the wait flag loops back as its own done.
// [RULE10] Every gated clock goes through its own global clock buffer stage; the code gates each one with a latch and an AND gate and has no buffer cell.
// [RULE11] The request pin is a top-level input driven by the outside controller.
// [RULE12] A persistent request raises the wait flag synchronous to sys_clk.
// [RULE13] On done the gate goes low and gated clocks stop within two cycles.
// [RULE14] After gating, the enable rises and stays high through entry and residence.
// [RULE15] Freeze active rises after housekeeping and gating, held until pin release.
// [RULE16] The request pin passes two flip-flops before persistence is judged.
module lpf_freeze_ctrl import lpf_pkg::*; #(
    parameter int NUM_CLK     = 2,
    parameter bit HAS_PIN_BUF = 1'b1,
    parameter bit HAS_ACCESS  = 1'b1
) (
    // Clock, enable, reset
    input  wire logic               sys_clk,
    input  wire logic               clk_en,
    input  wire logic               rst_n,
    // Freeze pin and user clocks
    input  wire logic               freeze_request_pin_n,
    input  wire logic [NUM_CLK-1:0] user_clk,
    output logic      [NUM_CLK-1:0] gated_clk,
    // Control outputs
    output logic                    wait_housekeeping_ff,
    output logic                    clock_gate_n_ff,
    output logic                    static_current_enable_ff,
    output logic                    freeze_active_ff,
    output logic                    freeze_mode_ff,
    // AXI4-Lite slave
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    // =====================================
    // Pin synchroniser and glitch filter
    localparam int GCYC = (`LPF_GLITCH_CYC < 1) ? 1 : `LPF_GLITCH_CYC;

    logic       pin_s1_ff;
    logic       pin_s2_ff;
    logic [3:0] glitch_cnt_ff;
    logic       req_ff;
    logic       pin_req;

    // Single buffer instance fed from the dedicated pin
    assign pin_req = HAS_PIN_BUF ? ~pin_s2_ff : 1'b0; // [RULE1] [RULE2] [RULE11]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else if (clk_en) begin
            pin_s1_ff <= freeze_request_pin_n; // [RULE16]
            pin_s2_ff <= pin_s1_ff;            // [RULE16]
        end
    end

    // A level must hold for the filter width before it counts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            glitch_cnt_ff <= 4'h0;
            req_ff        <= 1'b0;
        end else if (clk_en) begin
            if (pin_req == req_ff) begin
                glitch_cnt_ff <= 4'h0;
            // One lone sample straddling an edge must not pass
            end else if (glitch_cnt_ff >= 4'(GCYC)) begin
                req_ff        <= pin_req; // [RULE3]
                glitch_cnt_ff <= 4'h0;
            end else begin
                glitch_cnt_ff <= glitch_cnt_ff + 4'h1;
            end
        end
    end

    // =====================================
    // Registers
    logic        arm_ff;
    logic        hk_en_ff;
    logic        hk_done_ff;
    logic [31:0] persist_ff;

    // =====================================
    // Management state machine
    lpf_state_t  state_ff;
    lpf_state_t  nxt_state;
    logic [31:0] pcnt_ff;
    logic        hk_done;
    logic        sc_en_eff;
    lpf_ctl_t    nxt_ctl;

    // Housekeeping off: wait loops back to done; done is a register bit, wait still drives its output port
    assign hk_done   = hk_en_ff ? hk_done_ff : wait_housekeeping_ff; // [RULE9]
    // No access block: enable reads high; both parts needed for logic control
    assign sc_en_eff = HAS_ACCESS ? static_current_enable_ff : 1'b1; // [RULE6] [RULE7]

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LPF_IDLE:      if (req_ff && arm_ff && HAS_PIN_BUF) nxt_state = LPF_PERSIST;
            LPF_PERSIST:   if (!req_ff) nxt_state = LPF_IDLE;
                           else if (pcnt_ff >= persist_ff) nxt_state = LPF_HOUSEKEEP;
            LPF_HOUSEKEEP: if (hk_done) nxt_state = LPF_GATE;
            LPF_GATE:      if (pcnt_ff >= 32'h1) nxt_state = LPF_ENABLE; // [RULE13]
            LPF_ENABLE:    nxt_state = LPF_FROZEN;
            LPF_FROZEN:    if (!req_ff) nxt_state = LPF_EXIT;
            LPF_EXIT:      nxt_state = LPF_IDLE;
            default:       nxt_state = LPF_IDLE;
        endcase
    end

    always_comb begin
        nxt_ctl.wait_hk    = (nxt_state == LPF_HOUSEKEEP);                      // [RULE12]
        nxt_ctl.gate_n     = !(nxt_state inside {LPF_GATE, LPF_ENABLE, LPF_FROZEN}); // [RULE13]
        // Held through entry and residence, dropped only on exit
        nxt_ctl.sc_enable  = (nxt_state inside {LPF_ENABLE, LPF_FROZEN});       // [RULE8] [RULE14]
        nxt_ctl.frz_active = (nxt_state == LPF_FROZEN);                          // [RULE15]
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= LPF_IDLE;
            pcnt_ff  <= 32'h0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            pcnt_ff  <= (nxt_state == state_ff) ? pcnt_ff + 32'h1 : 32'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_housekeeping_ff     <= 1'b0;
            clock_gate_n_ff          <= 1'b1;
            static_current_enable_ff <= 1'b0;
            freeze_active_ff         <= 1'b0;
            freeze_mode_ff           <= 1'b0;
        end else if (clk_en) begin
            wait_housekeeping_ff     <= nxt_ctl.wait_hk;
            clock_gate_n_ff          <= nxt_ctl.gate_n;
            static_current_enable_ff <= nxt_ctl.sc_enable;
            freeze_active_ff         <= nxt_ctl.frz_active;
            // Hard block ANDs enable with the pin; low enable forces exit
            freeze_mode_ff           <= HAS_PIN_BUF && sc_en_eff && req_ff; // [RULE4] [RULE5]
        end
    end

    // =====================================
    // Clock gating filters, one latch and AND gate per clock
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CLK; gi++) begin : g_gate
            logic gate_ff;
            logic latch_q;
            // Gate retimed on its own clock, so it bites within two edges
            always_ff @(posedge user_clk[gi] or negedge rst_n) begin
                if (!rst_n) begin
                    gate_ff <= 1'b1;
                end else begin
                    gate_ff <= clock_gate_n_ff; // [RULE13]
                end
            end
            // Latch transparent while clock low avoids runt pulses
            always_latch begin
                if (!user_clk[gi]) begin
                    latch_q <= gate_ff;
                end
            end
            assign gated_clk[gi] = user_clk[gi] & latch_q; // [RULE10]
        end
    endgenerate

    // =====================================
    // AXI4-Lite slave
    logic [11:0] awaddr_ff;
    logic        aw_held_ff;
    logic [31:0] wdata_ff;
    logic        w_held_ff;

    function automatic logic [31:0] lpf_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    logic [3:0]  wstrb_ff;
    logic        wr_go;
    logic [31:0] ctrl_rd;
    logic [31:0] ctrl_new;
    assign wr_go   = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign ctrl_new = lpf_merge(ctrl_rd, wdata_ff, wstrb_ff);
    assign ctrl_rd = {29'h0, hk_done_ff, hk_en_ff, arm_ff};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            awaddr_ff    <= 12'h000;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LPF_RESP_OKAY;
            arm_ff       <= 1'(`LPF_CTRL_RST >> `LPF_CTRL_ARM);
            hk_en_ff     <= 1'b0;
            hk_done_ff   <= 1'b0;
            persist_ff   <= `LPF_PERSIST_RST;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `LPF_RESP_OKAY;
                if (awaddr_ff[11:2] == `LPF_OFS_CTRL >> 2) begin
                    {hk_done_ff, hk_en_ff, arm_ff} <= ctrl_new[2:0];
                end else if (awaddr_ff[11:2] == `LPF_OFS_PERSIST >> 2) begin
                    persist_ff <= lpf_merge(persist_ff, wdata_ff, wstrb_ff);
                end else if (awaddr_ff[11:2] != `LPF_OFS_STAT >> 2) begin
                    s_axi_bresp <= `LPF_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `LPF_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `LPF_RESP_OKAY;
                if (s_axi_araddr[11:2] == `LPF_OFS_CTRL >> 2) begin
                    s_axi_rdata <= ctrl_rd;
                end else if (s_axi_araddr[11:2] == `LPF_OFS_STAT >> 2) begin
                    s_axi_rdata <= {21'h0, 3'(state_ff), 3'h0, req_ff, freeze_active_ff,
                                    static_current_enable_ff, clock_gate_n_ff, wait_housekeeping_ff};
                end else if (s_axi_araddr[11:2] == `LPF_OFS_PERSIST >> 2) begin
                    s_axi_rdata <= persist_ff;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `LPF_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> hdl/lpf_map.svh
`ifndef LPF_MAP_SVH
`define LPF_MAP_SVH
// =====================================
// Register offsets
`define LPF_OFS_CTRL        12'h000
`define LPF_OFS_STAT        12'h004
`define LPF_OFS_PERSIST     12'h008
// =====================================
// Control field positions
`define LPF_CTRL_ARM        0
`define LPF_CTRL_HK_EN      1
`define LPF_CTRL_HK_DONE    2
`define LPF_CTRL_RST        32'h0000_0001
// =====================================
// Status field positions
`define LPF_STAT_WAIT       0
`define LPF_STAT_GATE_N     1
`define LPF_STAT_EN         2
`define LPF_STAT_ACTIVE     3
`define LPF_STAT_REQ        4
`define LPF_STAT_ST_LSB     8
// =====================================
// Timing
`define LPF_GLITCH_NS       2
`define LPF_CLK_NS          10
`define LPF_GLITCH_CYC      ((`LPF_GLITCH_NS + `LPF_CLK_NS - 1) / `LPF_CLK_NS)
`define LPF_PERSIST_RST     32'h0000_0004
// =====================================
// Bus answers
`define LPF_RESP_OKAY       2'h0
`define LPF_RESP_SLVERR     2'h2
`endif

// >>> hdl/lpf_pkg.sv
package lpf_pkg;
    typedef enum logic [2:0] {
        LPF_IDLE,
        LPF_PERSIST,
        LPF_HOUSEKEEP,
        LPF_GATE,
        LPF_ENABLE,
        LPF_FROZEN,
        LPF_EXIT
    } lpf_state_t;

    typedef struct packed {
        logic       wait_hk;
        logic       gate_n;
        logic       sc_enable;
        logic       frz_active;
    } lpf_ctl_t;
endpackage

// >>> tb/lpf_ctl_model.sv
`timescale 1ns/10ps
// ==========================================
// Outside controller owning the request pin
module lpf_ctl_model (
    // Clock
    input wire logic sys_clk,
    // Request pin
    output logic     freeze_request_pin_n
);
    initial freeze_request_pin_n = 1'b1;
    task automatic press();
        @(posedge sys_clk);
        freeze_request_pin_n <= 1'b0;
    endtask
    task automatic lift();
        @(posedge sys_clk);
        freeze_request_pin_n <= 1'b1;
    endtask
    // Straddles an edge so the sync flop really sees it
    task automatic glitch();
        @(posedge sys_clk);
        #9.5;
        freeze_request_pin_n = 1'b0;
        #1;
        freeze_request_pin_n = 1'b1;
    endtask
endmodule

// >>> tb/lpf_freeze_ctrl_props.sv
`timescale 1ns/10ps
// ==========================================
// Sequencing checks on the freeze controller
module lpf_freeze_ctrl_props #(
    parameter int NUM_CLK = 2
) (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Pin and gated clocks
    input wire logic               freeze_request_pin_n,
    input wire logic [NUM_CLK-1:0] gated_clk,
    // Sequencer outputs
    input wire logic               wait_housekeeping_ff,
    input wire logic               clock_gate_n_ff,
    input wire logic               static_current_enable_ff,
    input wire logic               freeze_active_ff,
    input wire logic               freeze_mode_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_SYNC_DELAY: assert property ($fell(freeze_request_pin_n) && !wait_housekeeping_ff && clock_gate_n_ff
        |=> !wait_housekeeping_ff [*3]) else $error("wait flag raised before the pin was synchronised");
    AST_GATE_AFTER_WAIT: assert property ($fell(clock_gate_n_ff) |-> $past(wait_housekeeping_ff))
        else $error("clock gate asserted without housekeeping wait");
    AST_ENABLE_AFTER_GATE: assert property ($fell(clock_gate_n_ff)
        |-> !static_current_enable_ff ##[1:4] static_current_enable_ff) else $error("enable late after gating");
    AST_ENABLE_NEEDS_GATE: assert property ($rose(static_current_enable_ff)
        |-> !clock_gate_n_ff && !wait_housekeeping_ff) else $error("enable rose before gating");
    AST_ACTIVE_FOLLOWS: assert property ($rose(static_current_enable_ff) |=> freeze_active_ff)
        else $error("freeze active did not follow the enable");
    AST_ACTIVE_HOLDS_EN: assert property (freeze_active_ff |-> static_current_enable_ff && !clock_gate_n_ff)
        else $error("enable or gate dropped while frozen");
    AST_ACTIVE_UNTIL_RELEASE: assert property ($fell(freeze_active_ff) |-> $past(freeze_request_pin_n, 2))
        else $error("freeze active fell while the pin was low");
    AST_MODE_NEEDS_EN: assert property (freeze_mode_ff |-> $past(static_current_enable_ff))
        else $error("freeze mode held with enable low");
    AST_MODE_LOW_PIN: assert property ($rose(freeze_mode_ff) |-> !$past(freeze_request_pin_n, 2))
        else $error("freeze mode entered with the pin high");
    AST_GATED_STOP: assert property (!clock_gate_n_ff [*8] |-> gated_clk == '0)
        else $error("gated clock still running");
endmodule
bind lpf_freeze_ctrl lpf_freeze_ctrl_props #(.NUM_CLK(NUM_CLK)) u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .freeze_request_pin_n(freeze_request_pin_n), .gated_clk(gated_clk),
    .wait_housekeeping_ff(wait_housekeeping_ff), .clock_gate_n_ff(clock_gate_n_ff),
    .static_current_enable_ff(static_current_enable_ff), .freeze_active_ff(freeze_active_ff),
    .freeze_mode_ff(freeze_mode_ff));

// >>> tb/tb.sv
`timescale 1ns/10ps
`include "lpf_map.svh"
module tb import lpf_pkg::*; ;
    logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, pin_n;
    logic [1:0]  user_clk = 2'h0, gated_clk, bresp, rresp;
    logic        hk_wait, gate_n, sc_en, active, mode;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    int          errors = 0, cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    always #10 user_clk[0] = ~user_clk[0];
    always #16 user_clk[1] = ~user_clk[1];
    lpf_freeze_ctrl u_dut (.sys_clk(sys_clk), .clk_en(clk_en), .rst_n(rst_n), .freeze_request_pin_n(pin_n),
        .user_clk(user_clk), .gated_clk(gated_clk), .wait_housekeeping_ff(hk_wait), .clock_gate_n_ff(gate_n),
        .static_current_enable_ff(sc_en), .freeze_active_ff(active), .freeze_mode_ff(mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    lpf_ctl_model u_ctl (.sys_clk(sys_clk), .freeze_request_pin_n(pin_n));
    // ==========================================
    // Compares and verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic results();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========================================
    // Register bus master
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge sys_clk);
        bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, bresp});
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge sys_clk);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, r}, {30'h0, rresp});
    endtask
    // Bounded wait; a miss shows up in the compares after it
    task automatic wait_active(input logic v);
        for (int i = 0; i < 300 && active !== v; i++) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // ==========================================
    // Scenarios
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        axi_rd(`LPF_OFS_CTRL, `LPF_CTRL_RST, `LPF_RESP_OKAY);
        axi_rd(`LPF_OFS_PERSIST, `LPF_PERSIST_RST, `LPF_RESP_OKAY);
        axi_wr(`LPF_OFS_STAT, 32'hFFFF_FFFF, `LPF_RESP_OKAY);
        axi_rd(`LPF_OFS_STAT, 32'h1 << `LPF_STAT_GATE_N, `LPF_RESP_OKAY);
        axi_wr(12'h00C, 32'h0000_0005, `LPF_RESP_SLVERR);
        axi_rd(12'h00C, 32'h0, `LPF_RESP_SLVERR);
        u_ctl.glitch();
        repeat (20) @(posedge sys_clk);
        chkb("glitch_wait", 1'b0, hk_wait);
        u_ctl.press();
        wait_active(1'b1);
        chkb("gate_n", 1'b0, gate_n);
        chkb("enable", 1'b1, sc_en);
        chkb("mode", 1'b1, mode);
        axi_rd(`LPF_OFS_STAT, (32'(LPF_FROZEN) << `LPF_STAT_ST_LSB) | 32'h1C, `LPF_RESP_OKAY);
        repeat (8) @(posedge sys_clk);
        chk("gated", 32'h0, {30'h0, gated_clk});
        u_ctl.lift();
        wait_active(1'b0);
        chkb("exit_en", 1'b0, sc_en);
        chkb("exit_mode", 1'b0, mode);
        axi_wr(`LPF_OFS_CTRL, 32'h0000_0003, `LPF_RESP_OKAY);
        u_ctl.press();
        for (int i = 0; i < 300 && hk_wait !== 1'b1; i++) @(posedge sys_clk);
        repeat (10) @(posedge sys_clk);
        chkb("hk_wait", 1'b1, hk_wait);
        chkb("hk_gate", 1'b1, gate_n);
        chkb("hk_en", 1'b0, sc_en);
        axi_wr(`LPF_OFS_CTRL, 32'h0000_0007, `LPF_RESP_OKAY);
        wait_active(1'b1);
        chkb("hk_done", 1'b0, hk_wait);
        chkb("hk_mode", 1'b1, mode);
        u_ctl.lift();
        wait_active(1'b0);
        axi_wr(`LPF_OFS_CTRL, 32'h0, `LPF_RESP_OKAY);
        u_ctl.press();
        repeat (40) @(posedge sys_clk);
        chkb("off_wait", 1'b0, hk_wait);
        chkb("off_mode", 1'b0, mode);
        u_ctl.lift();
        results();
    end
    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        results();
    end
endmodule
